// [cprc_pkg.sv]
package cprc_pkg;

  // ==========================================================
  // Clock and timing generator
  localparam int CLK_HZ = 20_000_000;     // pclk rate
  localparam int TICK_NS = 1000;          // Timing generator period in ns
  localparam int TICK_CYC = (TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int POR_TIME_US = 100;       // Power-on time-out
  localparam int CLEAR_TIME_US = 50;      // Configuration memory clear time
  localparam int POR_TICKS = POR_TIME_US * 1000 / TICK_NS;
  localparam int CLEAR_TICKS = CLEAR_TIME_US * 1000 / TICK_NS;
  localparam int TIMER_W = 12;            // Width of the phase timer
  localparam int REPROG_TICKS = 2;        // Reprogram request filter length
  localparam logic [6:0] PIN_IDLE_HIGH = 7'h48; // Pins that idle high: power-down and completion
  localparam int RB_BITS = 32;            // Bits per readback word
  localparam logic [1:0] STEP_ACTIVATE = 2'h1; // Startup step of user activation
  localparam logic [1:0] STEP_LAST = 2'h2;     // Last startup step

  // ==========================================================
  // Modes
  localparam logic [2:0] MODE_SLAVE = 3'h7; // Mode code that takes the clock in

  // ==========================================================
  // APB register map
  localparam logic [11:0] OFS_CTRL = 12'h000;   // Control, read/write
  localparam logic [11:0] OFS_STATUS = 12'h004; // Status, read only
  localparam logic [11:0] OFS_RBDATA = 12'h008; // Readback word, read/write
  localparam int CTRL_DONE_LATE_BIT = 0;        // Completion after activation
  localparam int CTRL_PULLUP_BIT = 1;           // Completion pin pull-up
  localparam int CTRL_LOAD_DONE_BIT = 2;        // Write 1: data load finished
  localparam logic [1:0] CTRL_RESET = 2'h0;     // Control reset value
  localparam logic [31:0] RBDATA_RESET = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef struct packed {
    logic power_down_n;  // Power-down pin, low active
    logic reset_n;       // Reset pin, low active
    logic config_clock;  // Configuration clock from the pin
    logic complete;      // Completion/reprogram pin level
    logic [2:0] mode;    // Mode pins, bit 0 doubles as readback trigger
  } cprc_pin_in_t;

  typedef enum logic [3:0] {
    ST_POR, ST_CLEAR, ST_WAIT_RST, ST_SAMPLE, ST_CONFIG, ST_STARTUP, ST_USER, ST_PDOWN
  } cprc_state_t;

endpackage : cprc_pkg

// [cprc_sync.sv]
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser for a bundle of level inputs
module cprc_sync #(
  parameter int W = 7 // Bundle width
) (
  input wire logic pclk,           // System clock
  input wire logic presetn,        // Async reset, low active
  input wire logic [W-1:0] d,      // Asynchronous inputs
  output logic [W-1:0] q           // Synchronised outputs
);
  logic [W-1:0] meta_ff; // First stage, read only by the second

  // Two flops in a row
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q <= '0;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule : cprc_sync

// [cprc_tick_div.sv]
`timescale 1ns/1ps
// ==========================================================
// Divider giving one-cycle enable pulses for the timing generator
module cprc_tick_div #(
  parameter int DIV = 20 // pclk cycles per tick
) (
  input wire logic pclk,    // System clock
  input wire logic presetn, // Async reset, low active
  input wire logic run,     // Low freezes the generator
  output logic tick         // One-cycle pulse every DIV cycles
);
  logic [15:0] cnt_ff; // Cycle counter

  // Count and pulse at wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (cnt_ff == 16'(DIV - 1)) begin
      cnt_ff <= 16'h0000;
      tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule : cprc_tick_div

// [cprc_top.sv]
`timescale 1ns/1ps
// Functional notes
// - Power-down suspends activity, outputs float, no pull-ups
// - Power-up after configuration resumes with startup sequence, no reload
// - Time-out and reset release precede mode sampling
// - Reset during configuration restarts configuration
// - Reset after configuration clears all storage
// - Drive clock except readback and slave mode other than startup after power-down
// - Open-drain completion, release before or after activation
// - Completion pin falling edge starts reconfiguration
// - Sample three mode pins before configuration
// - Mode0 rising edge starts readback on external clock
// - Mode1 pin outputs readback data inverted
// - Filter reprogram two ticks, hold pin low
// - Clear-status low during power-up and clearing
module cprc_top #(
  parameter int TICK_DIV = cprc_pkg::TICK_CYC,     // Cycles per timing tick
  parameter int POR_T = cprc_pkg::POR_TICKS,       // Power-on time-out ticks
  parameter int CLEAR_T = cprc_pkg::CLEAR_TICKS    // Memory clear ticks
) (
  input wire logic pclk,                           // APB clock
  input wire logic presetn,                        // APB reset, low active
  input wire logic psel,                           // APB select
  input wire logic penable,                        // APB enable
  input wire logic pwrite,                         // APB direction
  input wire logic [11:0] paddr,                   // APB byte address
  input wire logic [31:0] pwdata,                  // APB write data
  output logic [31:0] prdata,                      // APB read data
  output logic pready,                             // APB ready
  output logic pslverr,                            // APB error
  input wire cprc_pkg::cprc_pin_in_t pins_i,       // Control pins in
  output logic config_clock_o,                     // Configuration clock out
  output logic config_clock_oe,                    // Configuration clock drive
  output logic config_complete_reprogram_o,        // Completion pin level
  output logic config_complete_reprogram_oe,       // Completion pin pulled low
  output logic complete_pullup_en,                 // Completion pull-up on
  output logic mode_bit1_readback_out_o,           // Readback data, low active
  output logic mode_bit1_readback_out_oe,          // Readback pin drive
  output logic clear_status_oe,                    // Clear-status pin pulled low
  output logic io_output_en,                       // User outputs enabled
  output logic io_pullup_en,                       // Pin pull-ups on
  output logic storage_clear,                      // Clear all cell storage
  output logic user_logic_active,                  // User logic running
  output logic internal_suspend,                   // Internal activity halted
  output logic [2:0] config_mode                   // Sampled mode
);
  import cprc_pkg::*;

  // ==========================================================
  // Pin synchronisers and edge detection
  cprc_pin_in_t pins_s;     // Synchronised pins
  logic config_clock_d_ff;          // Delayed synchronised clock
  logic mode0_d_ff;         // Delayed synchronised trigger
  logic ext_rise;           // External clock rising edge
  logic trig_rise;          // Readback trigger rising edge
  logic tick;               // Timing generator pulse
  logic [6:0] sync_q;       // Synchroniser output, idle-high pins inverted

  // Idle-high pins pass inverted, so that after reset power-down is not seen asserted
  cprc_sync #(.W($bits(cprc_pin_in_t))) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(pins_i ^ PIN_IDLE_HIGH),
    .q(sync_q)
  );

  // Undo the inversion
  assign pins_s = cprc_pin_in_t'(sync_q ^ PIN_IDLE_HIGH);

  // Delay copies for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_clock_d_ff <= 1'b0;
      mode0_d_ff <= 1'b0;
    end else begin
      config_clock_d_ff <= pins_s.config_clock;
      mode0_d_ff <= pins_s.mode[0];
    end
  end

  assign ext_rise = pins_s.config_clock && !config_clock_d_ff;
  assign trig_rise = pins_s.mode[0] && !mode0_d_ff;

  // ==========================================================
  // APB slave
  logic [1:0] ctrl_ff;      // Done-late and pull-up selects
  logic load_done_ff;       // Software finished the data load
  logic [31:0] rbdata_ff;   // Word offered for readback
  logic wr_en;              // Write takes effect
  cprc_state_t state_ff;    // Sequencer state
  cprc_state_t nxt_state;   // Next sequencer state
  logic configured_ff;      // Configuration completed since the last clear
  logic rb_busy_ff;         // Readback in progress
  logic [2:0] mode_ff;      // Sampled mode

  // Decodes a mapped register
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_RBDATA);
  endfunction : addr_hit

  assign wr_en = psel && penable && pready && pwrite && addr_hit(paddr);

  // Answer one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= !addr_hit(paddr);
        case (paddr)
          OFS_CTRL: prdata <= {30'h0000_0000, ctrl_ff};
          OFS_STATUS: prdata <= {22'h00_0000, rb_busy_ff, configured_ff, 1'b0, mode_ff, 4'(state_ff)};
          OFS_RBDATA: prdata <= rbdata_ff;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and readback word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      rbdata_ff <= RBDATA_RESET;
    end else if (wr_en) begin
      if (paddr == OFS_CTRL) begin
        ctrl_ff <= {pwdata[CTRL_PULLUP_BIT], pwdata[CTRL_DONE_LATE_BIT]};
      end else if (paddr == OFS_RBDATA) begin
        rbdata_ff <= pwdata;
      end
    end
  end

  // Load-done flag, a new write wins over consumption
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_done_ff <= 1'b0;
    end else if (wr_en && paddr == OFS_CTRL && pwdata[CTRL_LOAD_DONE_BIT]) begin
      load_done_ff <= 1'b1;
    end else if (state_ff == ST_STARTUP || state_ff == ST_CLEAR) begin
      load_done_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  logic [TIMER_W-1:0] tmr_ff;  // Phase timer in ticks
  logic [1:0] step_ff;         // Startup step in clock cycles
  logic [1:0] filt_ff;         // Reprogram filter count
  logic resume_ff;             // Startup after power-down
  logic config_clock_ff;               // Own configuration clock
  logic use_own;               // Startup paced by own clock
  logic config_clock_run;              // Own clock is driven
  logic config_clock_edge;             // Configuration clock rising edge
  logic slave;                 // Sampled mode takes the clock in

  assign slave = (mode_ff == MODE_SLAVE);
  assign use_own = !slave || resume_ff;
  assign config_clock_run = (state_ff == ST_CONFIG && !slave) || (state_ff == ST_STARTUP && use_own);
  assign config_clock_edge = use_own ? (tick && config_clock_run && !config_clock_ff) : ext_rise;

  cprc_tick_div #(.DIV(TICK_DIV)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_ff != ST_PDOWN),
    .tick(tick)
  );

  // Next state
  always_comb begin
    nxt_state = state_ff;
    if (!pins_s.power_down_n && state_ff != ST_PDOWN) begin
      nxt_state = ST_PDOWN;
    end else begin
      case (state_ff)
        ST_POR: if (tick && tmr_ff == TIMER_W'(POR_T - 1)) nxt_state = ST_CLEAR;
        ST_CLEAR: if (tick && tmr_ff == TIMER_W'(CLEAR_T - 1)) nxt_state = ST_WAIT_RST;
        ST_WAIT_RST: if (pins_s.reset_n) nxt_state = ST_SAMPLE;
        ST_SAMPLE: nxt_state = ST_CONFIG;
        ST_CONFIG: begin
          if (!pins_s.reset_n) nxt_state = ST_CLEAR;
          else if (load_done_ff) nxt_state = ST_STARTUP;
        end
        ST_STARTUP: if (config_clock_edge && step_ff == STEP_LAST) nxt_state = ST_USER;
        ST_USER: if (filt_ff == 2'(REPROG_TICKS)) nxt_state = ST_CLEAR;
        ST_PDOWN: if (pins_s.power_down_n) nxt_state = configured_ff ? ST_STARTUP : ST_POR;
        default: nxt_state = ST_POR;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state_ff <= ST_POR;
    else state_ff <= nxt_state;
  end

  // Phase timer, restarted on each change of state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tmr_ff <= '0;
    else if (nxt_state != state_ff) tmr_ff <= '0;
    else if (tick) tmr_ff <= tmr_ff + 1'b1;
  end

  // Startup steps counted in clock cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) step_ff <= 2'h0;
    else if (state_ff != ST_STARTUP) step_ff <= 2'h0;
    else if (config_clock_edge) step_ff <= step_ff + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) filt_ff <= 2'h0;
    else if (state_ff != ST_USER || pins_s.complete) filt_ff <= 2'h0;
    else if (tick && filt_ff != 2'(REPROG_TICKS)) filt_ff <= filt_ff + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mode_ff <= 3'h0;
    else if (state_ff == ST_SAMPLE) mode_ff <= pins_s.mode;
  end

  // Configured and resume flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      configured_ff <= 1'b0;
      resume_ff <= 1'b0;
    end else begin
      if (state_ff == ST_USER) configured_ff <= 1'b1;
      else if (state_ff == ST_CLEAR) configured_ff <= 1'b0;
      if (state_ff == ST_PDOWN && nxt_state == ST_STARTUP) resume_ff <= 1'b1;
      else if (state_ff != ST_STARTUP) resume_ff <= 1'b0;
    end
  end

  // Own clock toggles on ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) config_clock_ff <= 1'b0;
    else if (!config_clock_run) config_clock_ff <= 1'b0;
    else if (tick) config_clock_ff <= !config_clock_ff;
  end

  // ==========================================================
  // Readback
  logic [RB_BITS-1:0] rb_shift_ff; // Outgoing bits, msb first
  logic [5:0] rb_cnt_ff;           // Bits left

  // start on the mode0 rising edge, shift on the external clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_busy_ff <= 1'b0;
      rb_shift_ff <= '0;
      rb_cnt_ff <= 6'h00;
    end else if (state_ff != ST_USER) begin
      rb_busy_ff <= 1'b0;
    // trigger only when configured and powered
    end else if (!rb_busy_ff && trig_rise && pins_s.power_down_n) begin
      rb_busy_ff <= 1'b1;
      rb_shift_ff <= rbdata_ff;
      rb_cnt_ff <= 6'(RB_BITS);
    end else if (rb_busy_ff && ext_rise) begin
      rb_shift_ff <= {rb_shift_ff[RB_BITS-2:0], 1'b0};
      rb_cnt_ff <= rb_cnt_ff - 6'h01;
      if (rb_cnt_ff == 6'h01) rb_busy_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Pin outputs
  logic nxt_user_active; // User logic active next cycle
  logic done_hold_ff;    // Completion pin held low
  logic clear_st_ff;     // Clear-status held low
  logic pullup_ff;       // Completion pull-up
  logic rb_out_ff;       // Readback pin level
  logic rb_oe_ff;        // Readback pin drive
  logic config_clock_oe_ff;      // Clock drive
  logic outen_ff;        // User outputs enabled
  logic iopull_ff;       // Pin pull-ups
  logic sclr_ff;         // Storage clear
  logic act_ff;          // User logic active
  logic susp_ff;         // Internal activity halted

  // activation on the middle startup step
  always_comb begin
    nxt_user_active = act_ff;
    if (nxt_state != ST_STARTUP && nxt_state != ST_USER) nxt_user_active = 1'b0;
    else if (state_ff == ST_STARTUP && config_clock_edge && step_ff == STEP_ACTIVATE) nxt_user_active = 1'b1;
  end

  // Completion pin hold and release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_hold_ff <= 1'b1;
    end else if (nxt_state == ST_PDOWN) begin
      done_hold_ff <= 1'b0;
    end else if (state_ff == ST_STARTUP && config_clock_edge) begin
      // release one cycle before or after activation
      if (step_ff == (ctrl_ff[CTRL_DONE_LATE_BIT] ? STEP_LAST : 2'h0)) done_hold_ff <= 1'b0;
    end else if (nxt_state != ST_USER && nxt_state != ST_STARTUP) begin
      done_hold_ff <= 1'b1;
    end else if (state_ff == ST_PDOWN) begin
      done_hold_ff <= 1'b1;
    end
  end

  // Registered pin levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_st_ff <= 1'b1;
      pullup_ff <= 1'b0;
      rb_out_ff <= 1'b1;
      rb_oe_ff <= 1'b0;
      config_clock_oe_ff <= 1'b0;
      outen_ff <= 1'b0;
      iopull_ff <= 1'b0;
      sclr_ff <= 1'b1;
      act_ff <= 1'b0;
      susp_ff <= 1'b0;
    end else begin
      clear_st_ff <= (nxt_state == ST_POR) || (nxt_state == ST_CLEAR);
      pullup_ff <= ctrl_ff[CTRL_PULLUP_BIT] && nxt_state != ST_PDOWN;
      rb_out_ff <= !(rb_busy_ff && rb_shift_ff[RB_BITS-1]);
      rb_oe_ff <= (nxt_state == ST_USER);
      config_clock_oe_ff <= config_clock_run;
      act_ff <= nxt_user_active;
      susp_ff <= (nxt_state == ST_PDOWN);
      outen_ff <= nxt_user_active && nxt_state != ST_PDOWN;
      iopull_ff <= nxt_state != ST_PDOWN && !nxt_user_active;
      // clear storage on reset after configuration
      sclr_ff <= !nxt_user_active || (state_ff == ST_USER && !pins_s.reset_n);
    end
  end

  assign config_clock_o = config_clock_ff;
  assign config_clock_oe = config_clock_oe_ff;
  assign config_complete_reprogram_o = 1'b0;
  assign config_complete_reprogram_oe = done_hold_ff;
  assign complete_pullup_en = pullup_ff;
  assign mode_bit1_readback_out_o = rb_out_ff;
  assign mode_bit1_readback_out_oe = rb_oe_ff;
  assign clear_status_oe = clear_st_ff;
  assign io_output_en = outen_ff;
  assign io_pullup_en = iopull_ff;
  assign storage_clear = sclr_ff;
  assign user_logic_active = act_ff;
  assign internal_suspend = susp_ff;
  assign config_mode = mode_ff;

  // ==========================================================
  // Assertions
  sequence s_reprog;
    state_ff == ST_USER ##1 state_ff == ST_CLEAR;
  endsequence

  a_pd_float: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_PDOWN && !pins_s.power_down_n) |=> !io_output_en && !io_pullup_en && !config_complete_reprogram_oe)
    else $error("power-down left a pin driven");
  a_pd_resume: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_PDOWN && pins_s.power_down_n && configured_ff) |=> state_ff == ST_STARTUP)
    else $error("power-down exit did not resume");
  a_cfg_restart: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_CONFIG && pins_s.power_down_n && !pins_s.reset_n) |=> state_ff == ST_CLEAR)
    else $error("reset during configuration ignored");
  a_user_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_USER && !pins_s.reset_n) |=> storage_clear)
    else $error("storage not cleared on reset");
  a_clk_dir: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_CONFIG) |=> config_clock_oe == !$past(slave))
    else $error("clock direction wrong");
  a_done_order: assert property (@(posedge pclk) disable iff (!presetn)
    ($fell(config_complete_reprogram_oe) && state_ff != ST_PDOWN)
      |-> user_logic_active == ctrl_ff[CTRL_DONE_LATE_BIT])
    else $error("completion released in wrong order");
  a_reprog_filt: assert property (@(posedge pclk) disable iff (!presetn)
    s_reprog |-> $past(filt_ff) == 2'(REPROG_TICKS) || !$past(pins_s.power_down_n))
    else $error("reprogram accepted unfiltered");
  a_init_low: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_POR || state_ff == ST_CLEAR) |-> clear_status_oe)
    else $error("clear-status released early");
  a_mode_take: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == ST_SAMPLE |=> config_mode == $past(pins_s.mode))
    else $error("mode not sampled");
  a_rb_gate: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(rb_busy_ff) |-> $past(state_ff) == ST_USER && $past(pins_s.power_down_n))
    else $error("readback started while not allowed");
endmodule : cprc_top

// [cprc_ctl_model.sv]
`timescale 1ns/1ps
// ==========================================================
// System controller that drives the control pins
module cprc_ctl_model (
  input wire logic pd_n,                   // Power-down request, low active
  input wire logic rst_n,                  // Reset request, low active
  input wire logic ext_run,                // Run the external clock
  input wire logic prog_low,               // Pull completion pin low
  input wire logic [2:0] mode,             // Mode pins as driven
  input wire logic clk_o,                  // Device clock out
  input wire logic clk_oe,                 // Device drives clock
  input wire logic cmp_oe,                 // Device pulls completion low
  input wire logic rb_o,                   // Readback data out
  input wire logic rb_oe,                  // Device drives mode bit 1
  output cprc_pkg::cprc_pin_in_t pins      // Pin levels seen by device
);
  import cprc_pkg::*;
  logic xclk = 1'b0; // External clock, still outside frames
  always #200 xclk = ext_run ? ~xclk : 1'b0;
  // wired levels, completion has a board pull-up
  assign pins = '{power_down_n: pd_n, reset_n: rst_n, config_clock: clk_oe ? clk_o : xclk,
                  complete: ~(cmp_oe | prog_low), mode: {mode[2], rb_oe ? rb_o : mode[1], mode[0]}};
endmodule : cprc_ctl_model

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import cprc_pkg::*;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} cprc_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pd_n = 1, rst_n = 0, ext_run = 0, prog_low = 0, err;
  logic [2:0] mode = 3'h5;
  logic clk_o, clk_oe, cmp_o, cmp_oe, cmp_pu, rb_o, rb_oe, clr_oe, io_en, io_pu, st_clr, ua, susp;
  logic [2:0] cfg_mode;
  cprc_pin_in_t pins;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  cprc_row_t rows [10] = '{
    '{1, 12'h000, 32'h0000_0003, 0, 0}, '{0, 12'h000, 0, 32'h0000_0003, 0},
    '{1, 12'h004, 32'hFFFF_FFFF, 0, 0}, '{1, 12'h008, 32'hA5C3_0F96, 0, 0},
    '{0, 12'h008, 0, 32'hA5C3_0F96, 0}, '{1, 12'h00C, 32'h1234_5678, 0, 1},
    '{0, 12'h00C, 0, 32'h0000_0000, 1}, '{1, 12'h000, 32'h0000_0000, 0, 0},
    '{0, 12'h000, 0, 32'h0000_0000, 0}, '{1, 12'h000, 32'h0000_0003, 0, 0}};
  cprc_top #(.TICK_DIV(4), .POR_T(4), .CLEAR_T(3)) cprc_top_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins_i(pins), .config_clock_o(clk_o), .config_clock_oe(clk_oe),
    .config_complete_reprogram_o(cmp_o), .config_complete_reprogram_oe(cmp_oe),
    .complete_pullup_en(cmp_pu), .mode_bit1_readback_out_o(rb_o), .mode_bit1_readback_out_oe(rb_oe),
    .clear_status_oe(clr_oe), .io_output_en(io_en), .io_pullup_en(io_pu), .storage_clear(st_clr),
    .user_logic_active(ua), .internal_suspend(susp), .config_mode(cfg_mode));
  cprc_ctl_model cprc_ctl_model_i (.pd_n(pd_n), .rst_n(rst_n), .ext_run(ext_run), .prog_low(prog_low),
    .mode(mode), .clk_o(clk_o), .clk_oe(clk_oe), .cmp_oe(cmp_oe), .rb_o(rb_o), .rb_oe(rb_oe), .pins(pins));
  initial begin
    forever #25 pclk = ~pclk;
  end
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Poll the state field with a bound
  task automatic wait_st(input cprc_state_t s);
    for (int i = 0; i < 300; i++) begin
      apb(0, 12'h004, 0);
      if (rd[3:0] === s) break;
    end
    chk(rd[3:0], s);
  endtask : wait_st
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(clr_oe, 1);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(err, rows[i].e);
      if (!rows[i].wr) chk(rd, rows[i].x);
    end
    wait_st(ST_WAIT_RST);
    rst_n <= 1;
    wait_st(ST_CONFIG);
    chk(cfg_mode, 3'h5);
    chk(clk_oe, 1);
    rst_n <= 0;
    wait_st(ST_WAIT_RST);
    rst_n <= 1;
    wait_st(ST_CONFIG);
    apb(1, 12'h000, 32'h0000_0007);
    for (int i = 0; i < 400 && ua !== 1'b1; i++) @(posedge pclk);
    chk(cmp_oe, 1);
    wait_st(ST_USER);
    chk({cmp_oe, cmp_pu, io_en, rb_oe}, 4'h7);
    mode <= 3'h4;
    apb(1, 12'h008, 32'h8000_0001);
    mode <= 3'h5;
    repeat (6) @(posedge pclk);
    apb(0, 12'h004, 0);
    chk(rd[9], 1);
    chk(rb_o, 0);
    ext_run <= 1;
    repeat (12) @(posedge pclk);
    chk(rb_o, 1);
    repeat (400) @(posedge pclk);
    apb(0, 12'h004, 0);
    chk(rd[9], 0);
    ext_run <= 0;
    mode <= 3'h4;
    pd_n <= 0;
    wait_st(ST_PDOWN);
    chk({susp, io_en, io_pu, cmp_pu}, 4'h8);
    mode <= 3'h5;
    repeat (6) @(posedge pclk);
    apb(0, 12'h004, 0);
    chk(rd[9], 0);
    pd_n <= 1;
    wait_st(ST_USER);
    chk({rd[8], io_en}, 2'h3);
    rst_n <= 0;
    repeat (6) @(posedge pclk);
    chk(st_clr, 1);
    rst_n <= 1;
    prog_low <= 1;
    repeat (2) @(posedge pclk);
    prog_low <= 0;
    wait_st(ST_USER);
    prog_low <= 1;
    mode <= 3'h7;
    wait_st(ST_CLEAR);
    chk(cmp_oe, 1);
    prog_low <= 0;
    wait_st(ST_CONFIG);
    chk({cfg_mode, clk_oe}, 4'hE);
    ext_run <= 1;
    apb(1, 12'h000, 32'h0000_0004);
    for (int i = 0; i < 400 && ua !== 1'b1; i++) @(posedge pclk);
    chk({ua, cmp_oe}, 2'h2);
    wait_st(ST_USER);
    ext_run <= 0;
    presetn <= 1'b0;
    @(posedge pclk);
    chk({clr_oe, st_clr, ua}, 3'h6);
    presetn <= 1'b1;
    wait_st(ST_CLEAR);
    results();
  end
endmodule : tb_top
